/* core/adc_bus_ctl.sv */
// Conversion sequencer and three-state byte read-out of the converter
`timescale 1ns/10ps
module adc_bus_ctl
  import adc_ctl_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // Host bus controls and mode
  input wire bus_ctl_t i_bus,
  input wire logic i_mode_select,
  // Result from the analog counter chain
  input wire result_t i_result,
  // Data bus
  output logic [7:0] o_data,
  output logic o_data_oe,
  // Status
  output logic o_busy,
  output logic o_data_valid
);
  logic tick_w;
  logic [1:0] phase_w;
  logic [7:0] byte_w;

  adc_clk_div4 u_div (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .o_tick(tick_w),
    .o_phase(phase_w)
  );

  conv_state_t state_r;
  conv_state_t state_nxt;
  logic [10:0] cnt_r;
  logic [10:0] cnt_nxt;
  logic running_w;
  logic pend_r;
  logic pend_nxt;
  logic wr_n_r;
  logic rd_n_r;
  logic busy_r;
  logic valid_r;
  logic valid_nxt;
  logic [1:0] idx_r;
  logic [1:0] idx_nxt;
  logic [7:0] data_r;
  result_t res_r;

  function automatic conv_state_t state_of(input logic [10:0] c);
    if (c < CNT_INTEG_BEG) begin
      state_of = ST_AUTOZERO;
    end else if (c < CNT_DEINT_BEG) begin
      state_of = ST_INTEGRATE;
    end else if (c < CNT_SETTLE_BEG) begin
      state_of = ST_DEINTEGRATE;
    end else begin
      state_of = ST_SETTLE;
    end
  endfunction

  // Bus qualification and edge detection
  logic sel_w;
  logic wr_fall_w;
  logic rd_rise_w;
  logic in_ignore_w;
  logic wr_acc_w;
  logic conv_end_w;
  logic start_go_w;
  logic busy_fall_w;
  logic lose_w;

  assign sel_w = ~i_bus.ce_n & i_bus.cs;
  assign wr_fall_w = sel_w & wr_n_r & ~i_bus.wr_n;
  assign rd_rise_w = sel_w & ~rd_n_r & i_bus.rd_n;
  assign running_w = (state_r != ST_IDLE);
  assign in_ignore_w = running_w & (cnt_r < CNT_IGNORE_END);
  assign wr_acc_w = wr_fall_w & ~i_mode_select & ~in_ignore_w;
  assign conv_end_w = tick_w & running_w & (cnt_r == CNT_LAST);
  // Busy-fall sits 125 cycles before the end; restart waits for the last count, not for busy-fall
  assign start_go_w = tick_w & (i_mode_select | pend_r) &
                      (~running_w | (cnt_r == CNT_LAST));
  assign busy_fall_w = tick_w & (state_r == ST_DEINTEGRATE) &
                       (cnt_r == CNT_SETTLE_BEG - 11'h001);
  // Two reference clocks ahead of the tick that raises busy
  assign lose_w = running_w & (cnt_r == CNT_LOSE) & (phase_w == HALF_PHASE);

  // Sequencer next state
  always_comb begin
    cnt_nxt = cnt_r;
    state_nxt = state_r;
    if (start_go_w) begin
      cnt_nxt = 11'h000;
      state_nxt = ST_AUTOZERO;
    end else if (conv_end_w) begin
      cnt_nxt = 11'h000;
      state_nxt = ST_IDLE;
    end else if (tick_w && running_w) begin
      cnt_nxt = cnt_r + 11'h001;
      state_nxt = state_of(cnt_r + 11'h001);
    end
  end

  // Set wins over clear, so a strobe at the restart tick is kept
  assign pend_nxt = wr_acc_w ? 1'b1 : (start_go_w ? 1'b0 : pend_r);
  assign valid_nxt = busy_fall_w ? 1'b1 : (lose_w ? 1'b0 : valid_r);

  always_comb begin
    idx_nxt = idx_r;
    if (busy_fall_w || lose_w) begin
      idx_nxt = BYTE_HI_POL;
    end else if (i_mode_select && rd_rise_w) begin
      idx_nxt = (idx_r == BYTE_HI_OVR) ? BYTE_HI_POL : idx_r + 2'h1;
    end
  end

  adc_byte_mux u_mux (
    .i_result(res_r),
    .i_mode_select(i_mode_select),
    .i_byte_sel_low(i_bus.byte_sel_low),
    .i_sign_over_select(i_bus.sign_over_select),
    .i_cont_idx(idx_r),
    .o_byte(byte_w)
  );

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      state_r <= ST_IDLE;
      cnt_r <= 11'h000;
      pend_r <= 1'b0;
      busy_r <= 1'b0;
      valid_r <= 1'b0;
      idx_r <= BYTE_HI_POL;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      pend_r <= pend_nxt;
      busy_r <= (state_nxt == ST_DEINTEGRATE);
      valid_r <= valid_nxt;
      idx_r <= idx_nxt;
    end
  end

  // Strobe history starts high so reset never looks like an edge
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      wr_n_r <= 1'b1;
      rd_n_r <= 1'b1;
      res_r <= '0;
      data_r <= 8'h00;
    end else begin
      wr_n_r <= i_bus.wr_n;
      rd_n_r <= i_bus.rd_n;
      if (busy_fall_w) begin
        res_r <= i_result;
      end
      data_r <= byte_w;
    end
  end

  assign o_data = data_r;
  assign o_data_oe = sel_w & ~i_bus.rd_n;
  assign o_busy = busy_r;
  assign o_data_valid = valid_r;

  // Helper: internal cycles spent integrating
  logic [9:0] integ_len_r;
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || state_r != ST_INTEGRATE) begin
      integ_len_r <= 10'h000;
    end else if (tick_w) begin
      integ_len_r <= integ_len_r + 10'h001;
    end
  end

  // Helper: internal cycles since the conversion began
  logic [10:0] since_start_r;
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || start_go_w) begin
      since_start_r <= 11'h000;
    end else if (tick_w && since_start_r != 11'h7ff) begin
      since_start_r <= since_start_r + 11'h001;
    end
  end

  property p_integ_len;
    @(posedge i_ref_clk) disable iff (i_srst)
      (state_r == ST_INTEGRATE) && (state_nxt == ST_DEINTEGRATE) |->
        integ_len_r == 10'(INTEG_CYCLES - 1);
  endproperty
  a_integ_len: assert property (p_integ_len)
    else $error("integrate phase not 256 cycles");

  property p_busy_fall_time;
    @(posedge i_ref_clk) disable iff (i_srst)
      $fell(o_busy) |-> since_start_r == CNT_SETTLE_BEG && o_data_valid;
  endproperty
  a_busy_fall_time: assert property (p_busy_fall_time)
    else $error("busy did not fall 1155 cycles after start");

  property p_conv_len;
    @(posedge i_ref_clk) disable iff (i_srst)
      start_go_w && running_w |-> since_start_r == CNT_LAST;
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("conversion not 1280 cycles long");

  property p_settle_gap;
    @(posedge i_ref_clk) disable iff (i_srst)
      $fell(o_busy) |-> !start_go_w [*8];
  endproperty
  a_settle_gap: assert property (p_settle_gap)
    else $error("restart too soon after busy fall");

  property p_ignore;
    @(posedge i_ref_clk) disable iff (i_srst)
      wr_fall_w && in_ignore_w && !pend_r |=> !pend_r;
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("write accepted inside ignore window");

  property p_remember;
    @(posedge i_ref_clk) disable iff (i_srst)
      wr_fall_w && !i_mode_select && running_w && cnt_r >= CNT_IGNORE_END |=> pend_r;
  endproperty
  a_remember: assert property (p_remember)
    else $error("late write not remembered");

  property p_no_repeat;
    @(posedge i_ref_clk) disable iff (i_srst)
      conv_end_w && !pend_r && !i_mode_select |=> state_r == ST_IDLE;
  endproperty
  a_no_repeat: assert property (p_no_repeat)
    else $error("conversion repeated without new edge");

  property p_back_to_back;
    @(posedge i_ref_clk) disable iff (i_srst)
      conv_end_w && i_mode_select |=> state_r == ST_AUTOZERO && cnt_r == 11'h000;
  endproperty
  a_back_to_back: assert property (p_back_to_back)
    else $error("continuous mode did not restart");

  property p_valid_drop;
    @(posedge i_ref_clk) disable iff (i_srst)
      lose_w |=> !o_data_valid ##2 o_busy;
  endproperty
  a_valid_drop: assert property (p_valid_drop)
    else $error("data not dropped half cycle before busy");

  property p_cont_order;
    @(posedge i_ref_clk) disable iff (i_srst)
      i_mode_select && rd_rise_w && idx_r == BYTE_HI_POL && !busy_fall_w && !lose_w
        |=> idx_r == BYTE_LO;
  endproperty
  a_cont_order: assert property (p_cont_order)
    else $error("byte counter did not advance");

  property p_top_bit;
    @(posedge i_ref_clk) disable iff (i_srst)
      !i_mode_select && !i_bus.byte_sel_low && i_bus.sign_over_select && !busy_fall_w
        |=> o_data[7] == res_r.overrange;
  endproperty
  a_top_bit: assert property (p_top_bit)
    else $error("top data bit not overrange");

  property p_reset_idle;
    @(posedge i_ref_clk) i_srst |=> !o_busy && !o_data_valid && state_r == ST_IDLE;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("not idle after reset");

  property p_busy_rise;
    @(posedge i_ref_clk) disable iff (i_srst)
      $rose(o_busy) |-> since_start_r == CNT_DEINT_BEG;
  endproperty
  a_busy_rise: assert property (p_busy_rise)
    else $error("busy did not rise at deintegrate start");

  property p_cont_low;
    @(posedge i_ref_clk) disable iff (i_srst)
      i_mode_select && idx_r == BYTE_LO && !busy_fall_w |=> o_data == res_r.magnitude[7:0];
  endproperty
  a_cont_low: assert property (p_cont_low)
    else $error("continuous low byte follows the selects");

  property p_demand_hold;
    @(posedge i_ref_clk) disable iff (i_srst)
      !i_mode_select && o_data_valid && !running_w |=> o_data_valid;
  endproperty
  a_demand_hold: assert property (p_demand_hold)
    else $error("demand data dropped while idle");

  property p_pend_clear;
    @(posedge i_ref_clk) disable iff (i_srst)
      start_go_w && !wr_acc_w |=> !pend_r;
  endproperty
  a_pend_clear: assert property (p_pend_clear)
    else $error("start strobe not consumed");

  c_demand_conv: cover property (@(posedge i_ref_clk) disable iff (i_srst)
    !i_mode_select && $fell(o_busy));
  c_cont_three: cover property (@(posedge i_ref_clk) disable iff (i_srst)
    i_mode_select && rd_rise_w && idx_r == BYTE_HI_OVR);
  c_queued: cover property (@(posedge i_ref_clk) disable iff (i_srst)
    start_go_w && running_w && pend_r);
  c_cont_lose: cover property (@(posedge i_ref_clk) disable iff (i_srst)
    i_mode_select && lose_w);
  c_ignored: cover property (@(posedge i_ref_clk) disable iff (i_srst)
    wr_fall_w && in_ignore_w);
endmodule

/* core/adc_ctl_pkg.sv */
// Shared constants and carriers for the integrating converter bus interface
// Contract
// - Input clock divided by four; one conversion lasts 1280 internal cycles.
// - Signal integrate phase lasts exactly 256 internal cycles.
// - Demand mode starts only on a selected write strobe low pulse.
// - Demand mode: busy falls, data valid, 1155 cycles after write falls.
// - After busy falls, 125 further cycles pass before the next conversion.
// - Write strobes ignored during the first 1100 cycles of a conversion.
// - Write accepted after the ignore window starts a conversion when current ends.
// - Only a falling write edge triggers; holding it low does not repeat.
// - Data valid from busy fall until half cycle before busy rises next.
// - Demand mode: three bytes independently addressable, any read order.
// - Continuous mode converts back to back, data valid at each busy fall.
// - Continuous mode ignores byte and sign select; bytes step on reads.
// - Result leaves on an 8-bit three-state bus under six control inputs.
// - Continuous order: high byte with polarity, low byte, high byte with overrange.
// - Continuous mode: each read strobe rising edge advances the byte counter.
// - Active-low enable ANDed with active-high select qualifies read and write.
// - Demand high byte top bit: overrange if select high, else polarity.
package adc_ctl_pkg;
  localparam int unsigned DIV_RATIO = 4;
  localparam logic [1:0] DIV_LAST = 2'h3;
  // Half an internal cycle before the next tick
  localparam logic [1:0] HALF_PHASE = 2'h1;
  localparam int unsigned CONV_CYCLES = 1280;
  localparam int unsigned INTEG_CYCLES = 256;
  localparam int unsigned BUSY_FALL_CYCLES = 1155;
  localparam int unsigned IGNORE_CYCLES = 1100;
  localparam logic [10:0] CNT_LAST = 11'(CONV_CYCLES - 1);
  localparam logic [10:0] CNT_INTEG_BEG = 11'h03f;
  localparam logic [10:0] CNT_DEINT_BEG = 11'(63 + INTEG_CYCLES);
  localparam logic [10:0] CNT_SETTLE_BEG = 11'(BUSY_FALL_CYCLES);
  localparam logic [10:0] CNT_IGNORE_END = 11'(IGNORE_CYCLES);
  localparam logic [10:0] CNT_LOSE = 11'(63 + INTEG_CYCLES - 1);
  localparam logic [1:0] BYTE_HI_POL = 2'h0;
  localparam logic [1:0] BYTE_LO = 2'h1;
  localparam logic [1:0] BYTE_HI_OVR = 2'h2;
  localparam int unsigned MAG_HI_MSB = 14;
  localparam int unsigned MAG_HI_LSB = 8;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_AUTOZERO = 5'h02,
    ST_INTEGRATE = 5'h04,
    ST_DEINTEGRATE = 5'h08,
    ST_SETTLE = 5'h10
  } conv_state_t;

  typedef struct packed {
    logic polarity_pos;
    logic overrange;
    logic [14:0] magnitude;
  } result_t;

  typedef struct packed {
    logic ce_n;
    logic cs;
    logic rd_n;
    logic wr_n;
    logic byte_sel_low;
    logic sign_over_select;
  } bus_ctl_t;
endpackage

/* core/adc_clk_div4.sv */
// Divide-by-four enable generator for the internal conversion clock
`timescale 1ns/10ps
module adc_clk_div4
  import adc_ctl_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // Internal clock enable
  output logic o_tick,
  output logic [1:0] o_phase
);
  logic [1:0] phase_r;

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      phase_r <= 2'h0;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end

  assign o_phase = phase_r;
  assign o_tick = (phase_r == DIV_LAST);

  property p_tick_spacing;
    @(posedge i_ref_clk) disable iff (i_srst)
      o_tick |=> !o_tick [*3] ##1 o_tick;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing)
    else $error("internal tick not one in four");
endmodule

/* core/adc_byte_mux.sv */
// Result byte selection for demand and continuous read-out
`timescale 1ns/10ps
module adc_byte_mux
  import adc_ctl_pkg::*;
(
  // Result and selection
  input wire result_t i_result,
  input wire logic i_mode_select,
  input wire logic i_byte_sel_low,
  input wire logic i_sign_over_select,
  input wire logic [1:0] i_cont_idx,
  // Selected byte
  output logic [7:0] o_byte
);
  function automatic logic [7:0] hi_byte(input logic top, input logic [14:0] mag);
    hi_byte = {top, mag[MAG_HI_MSB:MAG_HI_LSB]};
  endfunction

  logic [7:0] lo_w;
  logic [7:0] hi_pol_w;
  logic [7:0] hi_ovr_w;
  logic [7:0] demand_w;
  logic [7:0] cont_w;

  assign lo_w = i_result.magnitude[7:0];
  assign hi_pol_w = hi_byte(i_result.polarity_pos, i_result.magnitude);
  assign hi_ovr_w = hi_byte(i_result.overrange, i_result.magnitude);
  // Any order: low/high and top-bit meaning picked per read
  assign demand_w = i_byte_sel_low ? lo_w :
                    (i_sign_over_select ? hi_ovr_w : hi_pol_w);
  // Selects ignored here; the counter alone picks the byte
  assign cont_w = (i_cont_idx == BYTE_LO) ? lo_w :
                  ((i_cont_idx == BYTE_HI_OVR) ? hi_ovr_w : hi_pol_w);
  assign o_byte = i_mode_select ? cont_w : demand_w;
endmodule

/* verification/adc_host_port.sv */
// Host side stand-in that resolves the three-state data lines
`timescale 1ns/10ps
module adc_host_port (
  // Clock
  input wire logic i_ref_clk,
  // Converter data pins
  input wire logic [7:0] i_data,
  input wire logic i_data_oe,
  // Level seen by the host
  output logic [7:0] o_level
);
  logic [7:0] last_r = 8'h00;
  always @(posedge i_ref_clk) begin
    if (i_data_oe) begin
      last_r <= i_data;
    end
  end
  // Released lines show the inverse, so stale data never matches
  assign o_level = i_data_oe ? i_data : ~last_r;
endmodule

/* verification/integrating_adc_bus_interface_tb.sv */
// Self-checking bench of the converter sequencer and byte read-out
`timescale 1ns/10ps
module integrating_adc_bus_interface_tb;
  import adc_ctl_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic mode = 1'b0;
  bus_ctl_t bus = 6'h1c;
  result_t res = '0;
  logic [7:0] data;
  logic [7:0] level;
  logic [7:0] d;
  logic oe;
  logic busy;
  logic dv;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  int t0;
  int t1;
  int t2;

  adc_bus_ctl u_adc_bus_ctl (
    .i_ref_clk(clk),
    .i_srst(srst),
    .i_bus(bus),
    .i_mode_select(mode),
    .i_result(res),
    .o_data(data),
    .o_data_oe(oe),
    .o_busy(busy),
    .o_data_valid(dv)
  );
  adc_host_port u_adc_host_port (
    .i_ref_clk(clk),
    .i_data(data),
    .i_data_oe(oe),
    .o_level(level)
  );

  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Polls the end-of-conversion level, bounded
  task wait_busy(input logic lvl, input int lim);
    int k;
    k = 0;
    while (busy !== lvl && k < lim) begin
      @(negedge clk);
      k++;
    end
  endtask

  // Waits that must succeed count a timeout as a mismatch
  task expect_busy(input logic lvl, input int lim);
    wait_busy(lvl, lim);
    check(busy, lvl);
  endtask

  task wr(input logic ce_n, input logic cs);
    bus.ce_n = ce_n;
    bus.cs = cs;
    bus.wr_n = 1'b0;
    @(negedge clk);
    bus.wr_n = 1'b1;
    bus.ce_n = 1'b0;
    bus.cs = 1'b1;
  endtask

  // Read strobe returns high after each byte so the counter steps
  task rd(input logic sl, input logic so);
    bus.byte_sel_low = sl;
    bus.sign_over_select = so;
    bus.rd_n = 1'b0;
    repeat (2) @(negedge clk);
    d = level;
    bus.rd_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    print_verdict;
  end

  initial begin
    repeat (17) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    check({busy, dv}, 2'h0);
    res = '{1'b1, 1'b0, 15'h2a5c};
    // Strobe with only one of the two selects active
    for (int i = 0; i < 2; i++) begin
      wr(i == 0, i == 0);
      wait_busy(1'b1, 2000);
      check(busy, 1'b0);
    end
    // Strobe held low: one conversion only
    bus.wr_n = 1'b0;
    t0 = cyc;
    expect_busy(1'b1, 6000);
    t1 = cyc;
    expect_busy(1'b0, 6000);
    t2 = cyc;
    check(t2 - t1, 836 * DIV_RATIO);
    check((t2 - t0 > 1155 * 4) && (t2 - t0 <= 1155 * 4 + 5), 1'b1);
    check(dv, 1'b1);
    wait_busy(1'b1, 3000);
    check(busy, 1'b0);
    bus.wr_n = 1'b1;
    // Demand bytes in free order
    rd(1'b0, 1'b1);
    check(d, {1'b0, 7'h2a});
    rd(1'b1, 1'b1);
    check(d, 8'h5c);
    rd(1'b0, 1'b0);
    check(d, {1'b1, 7'h2a});
    bus.ce_n = 1'b1;
    bus.rd_n = 1'b0;
    @(negedge clk);
    check(oe, 1'b0);
    bus.rd_n = 1'b1;
    @(negedge clk);
    // Second strobe inside the ignore window is dropped
    wr(1'b0, 1'b1);
    repeat (400) @(negedge clk);
    wr(1'b0, 1'b1);
    expect_busy(1'b1, 6000);
    expect_busy(1'b0, 6000);
    wait_busy(1'b1, 2000);
    check(busy, 1'b0);
    // Strobe after the window is remembered until the end
    wr(1'b0, 1'b1);
    expect_busy(1'b1, 6000);
    expect_busy(1'b0, 6000);
    t1 = cyc;
    wr(1'b0, 1'b1);
    expect_busy(1'b1, 3000);
    check(cyc - t1, 444 * DIV_RATIO);
    check(dv, 1'b0);
    expect_busy(1'b0, 6000);
    // Continuous mode, selects set against the expected order
    res = '{1'b0, 1'b1, 15'h5a3c};
    mode = 1'b1;
    expect_busy(1'b1, 6000);
    expect_busy(1'b0, 6000);
    t1 = cyc;
    check(dv, 1'b1);
    // All three bytes taken well inside the read window
    rd(1'b1, 1'b0);
    check(d, {1'b0, 7'h5a});
    rd(1'b0, 1'b0);
    check(d, 8'h3c);
    rd(1'b1, 1'b0);
    check(d, {1'b1, 7'h5a});
    res = '{1'b1, 1'b0, 15'h1234};
    expect_busy(1'b1, 6000);
    expect_busy(1'b0, 6000);
    check(cyc - t1, CONV_CYCLES * DIV_RATIO);
    rd(1'b1, 1'b1);
    check(d, {1'b1, 7'h12});
    print_verdict;
  end
endmodule
